/* hw/sidt_irq.sv */
`timescale 1ns/1ps
module sidt_irq #(
  parameter int unsigned W = sidt_pkg::IRQ_W
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] event_set,
  input  wire logic         clr_wr,
  input  wire logic [W-1:0] clr_bits,
  input  wire logic         en_wr,
  input  wire logic [W-1:0] en_bits,
  output logic      [W-1:0] status,
  output logic      [W-1:0] enable,
  output logic              irq
);

  sidt_pkg::sidt_irq_state_t st_reg;
  sidt_pkg::sidt_irq_state_t st_next;

  always_comb
  begin
    // a new event wins over a clear in the same cycle
    st_next.status = (st_reg.status & ~(clr_wr ? clr_bits : '0)) | event_set;
    st_next.enable = en_wr ? en_bits : st_reg.enable;
    st_next.irq    = |(st_next.status & st_next.enable);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign status = st_reg.status;
  assign enable = st_reg.enable;
  assign irq    = st_reg.irq;

  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    irq == |(st_reg.status & st_reg.enable))
    else $error("interrupt level does not follow enabled status");

  a_event_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    |event_set |=> ((st_reg.status & $past(event_set)) == $past(event_set)))
    else $error("event lost against clear");

endmodule

/* hw/sidt_pkg.sv */
package sidt_pkg;

  localparam int unsigned UFRAMES    = 8;
  localparam int unsigned UF_IDX_W   = 3;
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned RESULT_W   = 3;
  localparam int unsigned FRAME_W    = 5;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned IRQ_W      = 3;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_SMASK    = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CMASK    = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_DW4      = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_DW5      = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_DW6      = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_DW7      = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLR  = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_IRQ_EN   = 8'h24;

  // control register fields
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned CTRL_IN_BIT    = 1;
  localparam int unsigned CTRL_FRAME_LSB = 8;

  // descriptor word field positions
  localparam int unsigned DW4_SMASK_LSB  = 0;
  localparam int unsigned DW4_RESULT_LSB = 8;
  localparam int unsigned DW5_CMASK_LSB  = 0;
  localparam int unsigned DW5_RX0_LSB    = 8;
  localparam int unsigned DW6_RX3_LSB    = 0;
  localparam int unsigned DW7_RX7_LSB    = 0;
  localparam int unsigned UF_DW5_LAST    = 2;
  localparam int unsigned UF_DW6_LAST    = 6;

  // per-microframe result bits
  localparam int unsigned RES_XERR_BIT     = 0;
  localparam int unsigned RES_BABBLE_BIT   = 1;
  localparam int unsigned RES_UNDERRUN_BIT = 2;

  // event bits
  localparam int unsigned IRQ_SS_BIT  = 0;
  localparam int unsigned IRQ_CS_BIT  = 1;
  localparam int unsigned IRQ_ERR_BIT = 2;

  localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;

  typedef struct packed {
    logic                                      enable;
    logic                                      dir_in;
    logic [FRAME_W-1:0]                        frame_target;
    logic [UFRAMES-1:0]                        smask;
    logic [UFRAMES-1:0]                        cmask;
    logic [UFRAMES-1:0][BYTE_W-1:0]            rx_byte;
    logic [UFRAMES-1:0][RESULT_W-1:0]          result;
    logic [UF_IDX_W-1:0]                       cur_uframe;
    logic                                      cur_match;
    logic                                      ss_issue;
    logic                                      cs_issue;
    logic [UF_IDX_W-1:0]                       issue_uframe;
    logic                                      pready;
    logic                                      pslverr;
    logic [DATA_W-1:0]                         prdata;
  } sidt_state_t;

  typedef struct packed {
    logic [IRQ_W-1:0] status;
    logic [IRQ_W-1:0] enable;
    logic             irq;
  } sidt_irq_state_t;

endpackage

/* hw/sidt_tracker.sv */
`timescale 1ns/1ps
// How it works
// - a byte received in microframe n is stored in received-byte field n only when start-split bit n is set and the frame matches.
// - each received-byte field is simply overwritten by every new reception in its microframe.
// - software may only set complete-split bits, and the block clears a bit once that microframe's complete split is done.
// - complete splits are issued only in microframes whose complete-split bit is set, and only for IN transfers.
// - start mask 0000 0001 with complete mask 0000 0100 gives the start split in microframe 0 and the complete split in 2.
// - a three-bit result is written per microframe, microframe 7 at bits 31 to 29 and 6 at 28 to 26 of word 4.
// - result bit 0 is transaction error, bit 1 babble on IN only, bit 2 underrun on OUT only.
module sidt_tracker (
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [sidt_pkg::ADDR_W-1:0]      paddr,
  input  wire logic [sidt_pkg::DATA_W-1:0]      pwdata,
  input  wire logic [sidt_pkg::DATA_W/8-1:0]    pstrb,
  output logic      [sidt_pkg::DATA_W-1:0]      prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  input  wire logic                             uframe_start,
  input  wire logic [sidt_pkg::UF_IDX_W-1:0]    uframe_index,
  input  wire logic [sidt_pkg::FRAME_W-1:0]     frame_number,
  input  wire logic                             rx_valid,
  input  wire logic [sidt_pkg::BYTE_W-1:0]      rx_data,
  input  wire logic                             result_valid,
  input  wire logic [sidt_pkg::RESULT_W-1:0]    result_flags,
  input  wire logic                             cs_done,
  output logic                                  ss_issue,
  output logic                                  cs_issue,
  output logic      [sidt_pkg::UF_IDX_W-1:0]    issue_uframe,
  output logic                                  irq
);

  sidt_pkg::sidt_state_t         s_reg;
  sidt_pkg::sidt_state_t         s_next;
  logic [sidt_pkg::IRQ_W-1:0]    ev_set;
  logic [sidt_pkg::IRQ_W-1:0]    irq_status;
  logic [sidt_pkg::IRQ_W-1:0]    irq_enable;
  logic                          wr_acc;
  logic                          clr_wr;
  logic                          en_wr;
  logic                          rx_take;
  logic                          cs_take;
  logic [sidt_pkg::RESULT_W-1:0] res_word;
  logic [sidt_pkg::DATA_W-1:0]   wmask;

  function automatic logic addr_ok(input logic [sidt_pkg::ADDR_W-1:0] a);
    addr_ok = (a == sidt_pkg::OFF_CTRL)     || (a == sidt_pkg::OFF_SMASK)  ||
              (a == sidt_pkg::OFF_CMASK)    || (a == sidt_pkg::OFF_DW4)    ||
              (a == sidt_pkg::OFF_DW5)      || (a == sidt_pkg::OFF_DW6)    ||
              (a == sidt_pkg::OFF_DW7)      || (a == sidt_pkg::OFF_IRQ_STAT) ||
              (a == sidt_pkg::OFF_IRQ_CLR)  || (a == sidt_pkg::OFF_IRQ_EN);
  endfunction

  function automatic logic [sidt_pkg::DATA_W-1:0] lane_mask(input logic [sidt_pkg::DATA_W/8-1:0] st);
    logic [sidt_pkg::DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < sidt_pkg::DATA_W / 8; i++)
    begin
      m[i*8 +: 8] = {8{st[i]}};
    end
    lane_mask = m;
  endfunction

  function automatic logic [sidt_pkg::DATA_W-1:0] read_word(
    input sidt_pkg::sidt_state_t        st,
    input logic [sidt_pkg::ADDR_W-1:0]  a,
    input logic [sidt_pkg::IRQ_W-1:0]   ist,
    input logic [sidt_pkg::IRQ_W-1:0]   ien
  );
    logic [sidt_pkg::DATA_W-1:0] w;
    w = sidt_pkg::RESET_WORD;
    unique case (a)
      sidt_pkg::OFF_CTRL:
      begin
        w[sidt_pkg::CTRL_EN_BIT] = st.enable;
        w[sidt_pkg::CTRL_IN_BIT] = st.dir_in;
        w[sidt_pkg::CTRL_FRAME_LSB +: sidt_pkg::FRAME_W] = st.frame_target;
      end
      sidt_pkg::OFF_SMASK:    w[sidt_pkg::UFRAMES-1:0] = st.smask;
      sidt_pkg::OFF_CMASK:    w[sidt_pkg::UFRAMES-1:0] = st.cmask;
      sidt_pkg::OFF_DW4:
      begin
        w[sidt_pkg::DW4_SMASK_LSB +: sidt_pkg::UFRAMES] = st.smask;
        w[sidt_pkg::DW4_RESULT_LSB +: sidt_pkg::UFRAMES*sidt_pkg::RESULT_W] = st.result;
      end
      sidt_pkg::OFF_DW5:
      begin
        w[sidt_pkg::DW5_CMASK_LSB +: sidt_pkg::UFRAMES] = st.cmask;
        w[sidt_pkg::DW5_RX0_LSB +: 3*sidt_pkg::BYTE_W] = st.rx_byte[sidt_pkg::UF_DW5_LAST:0];
      end
      sidt_pkg::OFF_DW6:
        w[sidt_pkg::DW6_RX3_LSB +: 4*sidt_pkg::BYTE_W] = st.rx_byte[sidt_pkg::UF_DW6_LAST:sidt_pkg::UF_DW5_LAST+1];
      // only the microframe 7 byte is live, the rest stays zero
      sidt_pkg::OFF_DW7:
        w[sidt_pkg::DW7_RX7_LSB +: sidt_pkg::BYTE_W] = st.rx_byte[sidt_pkg::UFRAMES-1];
      sidt_pkg::OFF_IRQ_STAT: w[sidt_pkg::IRQ_W-1:0] = ist;
      sidt_pkg::OFF_IRQ_EN:   w[sidt_pkg::IRQ_W-1:0] = ien;
      default:                w = sidt_pkg::RESET_WORD;
    endcase
    read_word = w;
  endfunction

  assign wr_acc  = psel && penable && s_reg.pready && pwrite;
  assign clr_wr  = wr_acc && (paddr == sidt_pkg::OFF_IRQ_CLR);
  assign en_wr   = wr_acc && (paddr == sidt_pkg::OFF_IRQ_EN);
  assign wmask   = lane_mask(pstrb);
  // babble only counts on IN, underrun only on OUT
  assign res_word = {result_flags[sidt_pkg::RES_UNDERRUN_BIT] & ~s_reg.dir_in,
                     result_flags[sidt_pkg::RES_BABBLE_BIT] & s_reg.dir_in,
                     result_flags[sidt_pkg::RES_XERR_BIT]};
  assign rx_take = rx_valid && s_reg.cur_match && s_reg.smask[s_reg.cur_uframe];
  assign cs_take = cs_done && s_reg.cur_match && s_reg.dir_in && s_reg.cmask[s_reg.cur_uframe];

  always_comb
  begin
    s_next          = s_reg;
    s_next.ss_issue = 1'b0;
    s_next.cs_issue = 1'b0;
    s_next.pready   = 1'b0;
    s_next.pslverr  = 1'b0;
    ev_set          = '0;

    if (uframe_start)
    begin
      s_next.cur_uframe = uframe_index;
      s_next.cur_match  = s_reg.enable && (frame_number == s_reg.frame_target);
      if (s_next.cur_match && s_reg.smask[uframe_index])
      begin
        s_next.ss_issue     = 1'b1;
        s_next.issue_uframe = uframe_index;
        ev_set[sidt_pkg::IRQ_SS_BIT] = 1'b1;
      end
      if (s_next.cur_match && s_reg.dir_in && s_reg.cmask[uframe_index])
      begin
        s_next.cs_issue     = 1'b1;
        s_next.issue_uframe = uframe_index;
      end
    end

    // plain overwrite, the previous byte is not kept
    if (rx_take)
    begin
      s_next.rx_byte[s_reg.cur_uframe] = rx_data;
    end

    if (result_valid && s_reg.cur_match)
    begin
      s_next.result[s_reg.cur_uframe] = res_word;
      ev_set[sidt_pkg::IRQ_ERR_BIT] = |res_word;
    end

    if (cs_take)
    begin
      s_next.cmask[s_reg.cur_uframe] = 1'b0;
      ev_set[sidt_pkg::IRQ_CS_BIT] = 1'b1;
    end

    if (wr_acc)
    begin
      unique case (paddr)
        sidt_pkg::OFF_CTRL:
        begin
          if (pstrb[0])
          begin
            s_next.enable = pwdata[sidt_pkg::CTRL_EN_BIT];
            s_next.dir_in = pwdata[sidt_pkg::CTRL_IN_BIT];
          end
          if (pstrb[1])
          begin
            s_next.frame_target = pwdata[sidt_pkg::CTRL_FRAME_LSB +: sidt_pkg::FRAME_W];
          end
        end
        sidt_pkg::OFF_SMASK:
          s_next.smask = pstrb[0] ? pwdata[sidt_pkg::UFRAMES-1:0] : s_reg.smask;
        // software only sets bits; applied after the clear so a set in the same cycle wins
        sidt_pkg::OFF_CMASK:
          s_next.cmask = s_next.cmask | (pwdata[sidt_pkg::UFRAMES-1:0] & wmask[sidt_pkg::UFRAMES-1:0]);
        default:
        begin
          // descriptor words are hardware written; word 7 upper bits always read as zero
        end
      endcase
    end

    if (psel && !penable)
    begin
      s_next.pready  = 1'b1;
      s_next.pslverr = !addr_ok(paddr);
      s_next.prdata  = pwrite ? sidt_pkg::RESET_WORD : read_word(s_reg, paddr, irq_status, irq_enable);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  sidt_irq #(
    .W (sidt_pkg::IRQ_W)
  ) u_irq (
    .pclk      (pclk),
    .presetn   (presetn),
    .event_set (ev_set),
    .clr_wr    (clr_wr),
    .clr_bits  (pwdata[sidt_pkg::IRQ_W-1:0]),
    .en_wr     (en_wr),
    .en_bits   (pwdata[sidt_pkg::IRQ_W-1:0]),
    .status    (irq_status),
    .enable    (irq_enable),
    .irq       (irq)
  );

  assign prdata       = s_reg.prdata;
  assign pready       = s_reg.pready;
  assign pslverr      = s_reg.pslverr;
  assign ss_issue     = s_reg.ss_issue;
  assign cs_issue     = s_reg.cs_issue;
  assign issue_uframe = s_reg.issue_uframe;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_rx_store_byte: assert property (
    rx_take |=> s_reg.rx_byte[$past(s_reg.cur_uframe)] == $past(rx_data))
    else $error("received byte not stored in its microframe field");

  a_rx_gated_off: assert property (
    rx_valid && !rx_take |=> $stable(s_reg.rx_byte))
    else $error("received byte stored without start-split bit or frame match");

  a_rx_overwrite: assert property (
    rx_take && s_reg.rx_byte[s_reg.cur_uframe] != rx_data
    |=> s_reg.rx_byte[$past(s_reg.cur_uframe)] == $past(rx_data))
    else $error("second reception did not overwrite the field");

  a_cs_mask_clear: assert property (
    cs_take && !(wr_acc && paddr == sidt_pkg::OFF_CMASK) |=> !s_reg.cmask[$past(s_reg.cur_uframe)])
    else $error("complete-split bit not cleared after processing");

  a_cs_in_only: assert property (
    s_reg.cs_issue |-> $past(s_reg.dir_in) && $past(s_reg.cmask[uframe_index]) && $past(uframe_start))
    else $error("complete split issued without IN direction or mask bit");

  a_ss_when_mask: assert property (
    uframe_start && s_reg.enable && frame_number == s_reg.frame_target && s_reg.smask[uframe_index]
    |=> s_reg.ss_issue && s_reg.issue_uframe == $past(uframe_index))
    else $error("start split missing in its microframe");

  a_result_field: assert property (
    result_valid && s_reg.cur_match |=> s_reg.result[$past(s_reg.cur_uframe)] == $past(res_word))
    else $error("microframe result not written to its field");

  a_result_direction: assert property (
    result_valid && s_reg.cur_match ##1 1'b1
    |-> !(s_reg.result[$past(s_reg.cur_uframe)][sidt_pkg::RES_BABBLE_BIT] && !$past(s_reg.dir_in)) &&
        !(s_reg.result[$past(s_reg.cur_uframe)][sidt_pkg::RES_UNDERRUN_BIT] && $past(s_reg.dir_in)))
    else $error("babble on an OUT transfer or underrun on an IN transfer recorded");

  a_dw7_upper_zero: assert property (
    psel && !penable && !pwrite && paddr == sidt_pkg::OFF_DW7
    |=> pready && prdata[sidt_pkg::DATA_W-1:sidt_pkg::BYTE_W] == '0)
    else $error("upper bits of word 7 not zero");

  a_cs_when_mask: assert property (
    uframe_start && s_reg.enable && frame_number == s_reg.frame_target &&
    s_reg.dir_in && s_reg.cmask[uframe_index]
    |=> s_reg.cs_issue && s_reg.issue_uframe == $past(uframe_index))
    else $error("complete split missing in its microframe");

  a_ss_only_masked: assert property (
    s_reg.ss_issue |-> s_reg.cur_match && $past(uframe_start) && $past(s_reg.smask[uframe_index]))
    else $error("start split issued without its mask bit");

  a_no_issue_unmatched: assert property (
    uframe_start && !(s_reg.enable && frame_number == s_reg.frame_target) |=> !s_reg.ss_issue && !s_reg.cs_issue)
    else $error("split issued in a frame that does not match");

  // a software set must survive, even against a hardware clear in the same cycle
  a_cmask_sw_set: assert property (
    wr_acc && paddr == sidt_pkg::OFF_CMASK && pstrb[0]
    |=> (s_reg.cmask & $past(pwdata[sidt_pkg::UFRAMES-1:0])) == $past(pwdata[sidt_pkg::UFRAMES-1:0]))
    else $error("software set of a complete-split bit lost");

  a_result_gated: assert property (
    result_valid && !s_reg.cur_match |=> $stable(s_reg.result))
    else $error("microframe result written without a frame match");

  a_err_event: assert property (
    result_valid && s_reg.cur_match && |res_word |=> irq_status[sidt_pkg::IRQ_ERR_BIT])
    else $error("error result did not raise its event");

  c_ss_then_cs: cover property (s_reg.ss_issue ##[1:20] s_reg.cs_issue);
  c_rx_stored: cover property (rx_take);
  c_cs_cleared: cover property (cs_take);
  c_bad_address: cover property (pready && pslverr);
  c_error_result: cover property (result_valid && s_reg.cur_match && |res_word);

endmodule

/* testbench/sidt_hub_model.sv */
`timescale 1ns/1ps
module sidt_hub_model (
  input  wire logic       pclk,
  input  wire logic       ss_issue,
  input  wire logic       cs_issue,
  input  wire logic [2:0] issue_uframe,
  output logic            uframe_start,
  output logic      [2:0] uframe_index,
  output logic      [4:0] frame_number,
  output logic            rx_valid,
  output logic      [7:0] rx_data,
  output logic            result_valid,
  output logic      [2:0] result_flags,
  output logic            cs_done
);
  initial
  begin
    uframe_start = 1'b0;
    uframe_index = 3'h0;
    frame_number = 5'h00;
    rx_valid     = 1'b0;
    rx_data      = 8'h00;
    result_valid = 1'b0;
    result_flags = 3'h0;
    cs_done      = 1'b0;
  end

  // released lines show the inverse so a stale value can never look valid
  task automatic run_uframe(input logic [2:0] idx, input logic [4:0] fr, input logic [7:0] d,
                            input logic [2:0] fl, input int lag,
                            output logic ss, output logic cs, output logic [2:0] iu);
    @(posedge pclk);
    uframe_start <= 1'b1;
    uframe_index <= idx;
    frame_number <= fr;
    @(posedge pclk);
    uframe_start <= 1'b0;
    uframe_index <= ~idx;
    frame_number <= ~fr;
    @(posedge pclk);
    ss = ss_issue;
    cs = cs_issue;
    iu = issue_uframe;
    // a slow translator answers some cycles late
    repeat (lag) @(posedge pclk);
    rx_valid <= 1'b1;
    rx_data <= d;
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_data <= ~d;
    result_valid <= 1'b1;
    result_flags <= fl;
    @(posedge pclk);
    result_valid <= 1'b0;
    result_flags <= ~fl;
    cs_done <= cs;
    @(posedge pclk);
    cs_done <= 1'b0;
  endtask
endmodule

/* testbench/split_interrupt_descriptor_tracker_bench.sv */
`timescale 1ns/1ps
module split_interrupt_descriptor_tracker_bench;
  typedef struct packed
  {
    logic [2:0] idx;
    logic [7:0] data;
    logic [2:0] flags;
    logic [2:0] res;
  } sidt_row_t;

  logic             pclk;
  logic             presetn;
  logic             psel;
  logic             penable;
  logic             pwrite;
  logic [7:0]       paddr;
  logic [31:0]      pwdata;
  logic [3:0]       pstrb;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic             uframe_start;
  logic [2:0]       uframe_index;
  logic [4:0]       frame_number;
  logic             rx_valid;
  logic [7:0]       rx_data;
  logic             result_valid;
  logic [2:0]       result_flags;
  logic             cs_done;
  logic             ss_issue;
  logic             cs_issue;
  logic [2:0]       issue_uframe;
  logic             irq;
  logic [31:0]      rd;
  logic             err;
  logic             ss;
  logic             cs;
  logic [2:0]       iu;
  logic [7:0][7:0]  rx_exp;
  logic [7:0][2:0]  res_exp;
  int               num_errors;
  int               n_checks;
  int               cycles;
  // out direction keeps underrun and drops babble; the first byte has a bit the last lacks, so or-ing would show
  sidt_row_t        rows[9] = '{'{3'd0, 8'h11, 3'b111, 3'b101}, '{3'd1, 8'h22, 3'b010, 3'b000},
                                '{3'd2, 8'h33, 3'b100, 3'b100}, '{3'd3, 8'h44, 3'b001, 3'b001},
                                '{3'd4, 8'h55, 3'b011, 3'b001}, '{3'd5, 8'h66, 3'b110, 3'b100},
                                '{3'd6, 8'h77, 3'b101, 3'b101}, '{3'd7, 8'h88, 3'b000, 3'b000},
                                '{3'd0, 8'h9e, 3'b010, 3'b000}};

  sidt_tracker dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
                      .pready, .pslverr, .uframe_start, .uframe_index, .frame_number, .rx_valid,
                      .rx_data, .result_valid, .result_flags, .cs_done, .ss_issue, .cs_issue,
                      .issue_uframe, .irq);

  sidt_hub_model hub_u (.pclk, .ss_issue, .cs_issue, .issue_uframe, .uframe_start, .uframe_index,
                        .frame_number, .rx_valid, .rx_data, .result_valid, .result_flags, .cs_done);

  always #2.5 pclk = ~pclk;

  task automatic conclude();
    if (num_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      num_errors++;
      conclude();
    end
  end

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    num_errors = 0;
    n_checks = 0;
    cycles = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a <= 'h24; a += 4)
    begin
      // the clear register is write-only, nothing defined to read back
      if (a != 'h20)
      begin
        apb(8'(a), 1'b0, 32'h0);
        check("reset value", 32'h0, rd);
      end
    end
    apb(8'h28, 1'b0, 32'h0);
    check("unmapped error", 32'h1, {31'h0, err});
    apb(sidt_pkg::OFF_CTRL, 1'b1, 32'h0000_0501);
    apb(sidt_pkg::OFF_SMASK, 1'b1, 32'h0000_00ff);
    apb(sidt_pkg::OFF_CMASK, 1'b1, 32'h0000_00ff);
    foreach (rows[i])
    begin
      hub_u.run_uframe(rows[i].idx, 5'h05, rows[i].data, rows[i].flags, i % 3, ss, cs, iu);
      check("ss_issue", 32'h1, {31'h0, ss});
      check("cs_issue out", 32'h0, {31'h0, cs});
      check("issue_uframe", {29'h0, rows[i].idx}, {29'h0, iu});
      rx_exp[rows[i].idx] = rows[i].data;
      res_exp[rows[i].idx] = rows[i].res;
    end
    apb(sidt_pkg::OFF_DW4, 1'b0, 32'h0);
    check("word 4", {res_exp, 8'hff}, rd);
    apb(sidt_pkg::OFF_DW5, 1'b0, 32'h0);
    check("word 5", {rx_exp[2:0], 8'hff}, rd);
    apb(sidt_pkg::OFF_DW6, 1'b0, 32'h0);
    check("word 6", rx_exp[6:3], rd);
    apb(sidt_pkg::OFF_DW7, 1'b1, 32'hffff_ffff);
    apb(sidt_pkg::OFF_DW7, 1'b0, 32'h0);
    check("word 7", {24'h0, rx_exp[7]}, rd);
    apb(sidt_pkg::OFF_IRQ_STAT, 1'b0, 32'h0);
    check("irq status", 32'h5, rd);
    check("irq masked", 32'h0, {31'h0, irq});
    apb(sidt_pkg::OFF_IRQ_CLR, 1'b1, 32'h7);
    apb(sidt_pkg::OFF_IRQ_STAT, 1'b0, 32'h0);
    check("irq cleared", 32'h0, rd);
    // second reset mid-run drops the complete-split bits software set, as no OUT split ever clears them
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(sidt_pkg::OFF_CMASK, 1'b0, 32'h0);
    check("cmask after reset", 32'h0, rd);
    apb(sidt_pkg::OFF_CTRL, 1'b1, 32'h0000_0503);
    apb(sidt_pkg::OFF_SMASK, 1'b1, 32'h0000_0001);
    apb(sidt_pkg::OFF_CMASK, 1'b1, 32'h0000_0004);
    apb(sidt_pkg::OFF_IRQ_EN, 1'b1, 32'h2);
    hub_u.run_uframe(3'd0, 5'h05, 8'ha5, 3'b110, 0, ss, cs, iu);
    check("start split uf0", 32'h1, {31'h0, ss});
    check("no cs uf0", 32'h0, {31'h0, cs});
    check("irq start masked", 32'h0, {31'h0, irq});
    hub_u.run_uframe(3'd0, 5'h06, 8'h77, 3'b001, 0, ss, cs, iu);
    check("wrong frame", 32'h0, {30'h0, ss, cs});
    hub_u.run_uframe(3'd2, 5'h05, 8'h3c, 3'b000, 2, ss, cs, iu);
    check("split uf2", 32'h1, {30'h0, ss, cs});
    check("issue_uframe uf2", 32'h2, {29'h0, iu});
    apb(sidt_pkg::OFF_DW5, 1'b0, 32'h0);
    check("word 5 in", 32'h0000_a500, rd);
    apb(sidt_pkg::OFF_DW4, 1'b0, 32'h0);
    check("word 4 in", 32'h0000_0201, rd);
    check("irq cs done", 32'h1, {31'h0, irq});
    apb(sidt_pkg::OFF_IRQ_CLR, 1'b1, 32'h2);
    @(posedge pclk);
    check("irq released", 32'h0, {31'h0, irq});
    // lane 1 alone moves the frame target and leaves enable and direction alone
    pstrb <= 4'h2;
    apb(sidt_pkg::OFF_CTRL, 1'b1, 32'h0000_1f00);
    pstrb <= 4'hf;
    apb(sidt_pkg::OFF_CTRL, 1'b0, 32'h0);
    check("ctrl lane 1", 32'h0000_1f03, rd);
    conclude();
  end
endmodule
